// ===== hdl/cmp_vref_ctrl.sv
// Digital control for the on-chip comparator and its resistor-ladder
// reference, with AHB-Lite register access and the change-flag logic.
// Assumes the analog comparator output is asynchronous to clk_in.
//
// Functional notes
// - Reference offers 32 levels: 16 tap codes in each of two ranges.
// - Low range: reference equals tap code over 24 times supply.
// - High range: supply quarter plus tap code times supply over 32.
// - Ladder control bit 7 powers the ladder on; clear powers it down.
// - Ladder control bit 5 set selects low range, clear selects high.
// - Ladder control bits 3..0 hold tap code 0 to 15.
// - Comparator and ladder stay operating through sleep if enabled.
// - Mode 111 switches the comparator off for lowest sleep power.
// - During sleep an enabled comparator's change flag wakes the device.
// - Waking from sleep leaves both control registers unchanged.
// - Reset loads reset states: mode 000 and ladder off.
// - In reset configuration all comparator pins are analog inputs.
// - Flag sets whenever the comparator output differs from latched value.
// - Flag is bit 3 of peripheral flags; only software clears it.
// - Software writing one to the flag sets it.
// - Interrupt reaches core only if change, peripheral and global enables set.
// - Flag still sets when any enable is clear.
// - Any read or write of comparator control latches the output.
// - Persisting mismatch keeps setting the flag after a software clear.
// - A change coinciding with a control read may miss setting the flag.
// - Result bit reports comparison inverted when invert bit is set.
// - In modes 110 and 101 input switch picks the negative input pin.
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "cmp_vref_defs.svh"
module cmp_vref_ctrl
    import cmp_vref_pkg::*;
#(
    parameter int SYNC_DEPTH = `SYNC_STAGES
) (
    // Clock, reset and clock enable
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        ce_in,
    // AHB-Lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic [31:0]      hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // Analog front end
    input  wire logic        compare_raw_in,
    input  wire logic        sleep_in,
    output logic [2:0]       comparator_mode_code_out,
    output logic             result_invert_out,
    output logic             input_switch_out,
    output logic             neg_from_pos_pin_out,
    output logic             comparator_on_out,
    output logic             ladder_power_on_out,
    output logic             ladder_range_low_out,
    output logic [3:0]       ladder_tap_code_out,
    output logic [4:0]       internal_ref_level_out,
    output logic [5:0]       port_a_direction_out,
    output logic             pins_all_analog_out,
    // Core interrupt and wake
    output logic             core_irq_out,
    output logic             wake_out
);
    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [7:0]  core_interrupt_control_r;
    logic [7:0]  peripheral_flag_one_r;
    logic [7:0]  comparator_control_r;
    logic [7:0]  port_a_direction_r;
    logic [7:0]  peripheral_enable_one_r;
    logic [7:0]  reference_ladder_control_r;
    logic        latched_result_r;
    bus_state_e  bus_state_r;
    logic        wr_pend_r;
    logic [7:0]  addr_idx_r;

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    wire         addr_phase  = hsel_in && hready_in && htrans_in[1];
    wire [7:0]   addr_idx_a  = haddr_in[9:2];
    wire         data_write  = (bus_state_r == BUS_DATA) && wr_pend_r;
    wire         data_phase  = (bus_state_r == BUS_DATA);
    wire [7:0]   wbyte       = hwdata_in[7:0];
    wire         sel_cic     = (addr_idx_r == `IDX_CORE_INT_CTRL);
    wire         sel_pf      = (addr_idx_r == `IDX_PERIPH_FLAG);
    wire         sel_cc      = (addr_idx_r == `IDX_CMP_CTRL);
    wire         sel_pad     = (addr_idx_r == `IDX_PORTA_DIR);
    wire         sel_pe      = (addr_idx_r == `IDX_PERIPH_EN);
    wire         sel_lc      = (addr_idx_r == `IDX_LADDER_CTRL);
    wire         sel_st      = (addr_idx_r == `IDX_LINK_STATUS);
    wire         cc_touch_a  = addr_phase && (addr_idx_a == `IDX_CMP_CTRL);

    // ------------------------------------------------------------------------
    // Comparator result path
    // ------------------------------------------------------------------------
    logic        raw_sync;
    pin_sync #(
        .STAGES    (SYNC_DEPTH)
    ) u_sync (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .ce_in     (ce_in),
        .async_in  (compare_raw_in),
        .level_out (raw_sync)
    );

    wire [2:0]   mode_code  = comparator_control_r[2:0];
    wire         cmp_on     = (mode_code != MODE_OFF) && (mode_code != MODE_RESET);
    wire         result_now = cmp_on &&
                              (raw_sync ^ comparator_control_r[`BIT_INVERT]);
    wire         mismatch   = (result_now != latched_result_r);
    // A change in the same cycle as a comparator control access is absorbed by the latch.
    wire         change_set = mismatch && !cc_touch_a;
    wire         flag_now   = peripheral_flag_one_r[`BIT_CHANGE_FLAG];
    wire         flag_wr    = data_write && sel_pf;
    // Hardware set wins over a software clear in the same cycle.
    wire         flag_nxt   = change_set ? 1'b1 :
                              (flag_wr ? wbyte[`BIT_CHANGE_FLAG] : flag_now);

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    wire         irq_gate   = peripheral_enable_one_r[`BIT_CHANGE_EN] &&
                              core_interrupt_control_r[`BIT_PERIPH_EN] &&
                              core_interrupt_control_r[`BIT_GLOBAL_EN];
    wire         lo_range   = reference_ladder_control_r[`BIT_RANGE_LOW];
    wire [3:0]   tap        = reference_ladder_control_r[3:0];
    wire         use_switch = (mode_code == MODE_SW_LOW) || (mode_code == MODE_SW_HIGH);

    assign comparator_mode_code_out = mode_code;
    assign result_invert_out        = comparator_control_r[`BIT_INVERT];
    assign input_switch_out         = comparator_control_r[`BIT_SWITCH];
    assign neg_from_pos_pin_out     = use_switch && comparator_control_r[`BIT_SWITCH];
    // Sleep gates nothing here, so enabled analog parts keep running.
    assign comparator_on_out        = cmp_on;
    assign ladder_power_on_out      = reference_ladder_control_r[`BIT_LADDER_ON];
    assign ladder_range_low_out     = lo_range;
    assign ladder_tap_code_out      = tap;
    // Level index 0..31: low range on 0..15, high range on 16..31.
    assign internal_ref_level_out   = {~lo_range, tap};
    assign port_a_direction_out     = port_a_direction_r[5:0];
    assign pins_all_analog_out      = (mode_code == MODE_RESET);
    assign core_irq_out             = flag_now && irq_gate;
    // Wake needs only the change enable; the core decides on vectoring.
    assign wake_out = sleep_in && cmp_on && flag_now &&
                      peripheral_enable_one_r[`BIT_CHANGE_EN];
    assign hreadyout_out            = 1'b1;
    assign hresp_out                = 1'b0;

    wire [7:0] rd_byte =
        sel_cic ? core_interrupt_control_r :
        sel_pf  ? peripheral_flag_one_r :
        sel_cc  ? {1'b0, latched_result_r, 1'b0, comparator_control_r[4:0]} :
        sel_pad ? port_a_direction_r :
        sel_pe  ? peripheral_enable_one_r :
        sel_lc  ? reference_ladder_control_r :
        sel_st  ? {6'h00, result_now, mismatch} : 8'h00;
    assign hrdata_out = {24'h00_0000, rd_byte};

    // ------------------------------------------------------------------------
    // Sequential logic
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            bus_state_r <= BUS_IDLE;
            wr_pend_r   <= 1'b0;
            addr_idx_r  <= 8'h00;
        end else if (ce_in) begin
            bus_state_r <= addr_phase ? BUS_DATA : BUS_IDLE;
            wr_pend_r   <= addr_phase && hwrite_in;
            addr_idx_r  <= addr_phase ? addr_idx_a : addr_idx_r;
        end
    end

    // Sleep and wake never touch the control registers.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            core_interrupt_control_r   <= `RST_CORE_INT_CTRL;
            comparator_control_r       <= `RST_CMP_CTRL;
            port_a_direction_r         <= `RST_PORTA_DIR;
            peripheral_enable_one_r    <= `RST_PERIPH_EN;
            reference_ladder_control_r <= `RST_LADDER_CTRL;
        end else if (ce_in && data_write) begin
            if (sel_cic) begin
                core_interrupt_control_r <= wbyte;
            end else if (sel_cc) begin
                comparator_control_r <= wbyte & `MASK_CMP_CTRL;
            end else if (sel_pad) begin
                port_a_direction_r <= wbyte & `MASK_PORTA_DIR;
            end else if (sel_pe) begin
                peripheral_enable_one_r <= wbyte & `MASK_PERIPH;
            end else if (sel_lc) begin
                reference_ladder_control_r <= wbyte & `MASK_LADDER;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            peripheral_flag_one_r <= `RST_PERIPH_FLAG;
            latched_result_r      <= 1'b0;
        end else if (ce_in) begin
            if (flag_wr) begin
                peripheral_flag_one_r <= wbyte & `MASK_PERIPH;
            end
            peripheral_flag_one_r[`BIT_CHANGE_FLAG] <= flag_nxt;
            if (cc_touch_a) begin
                latched_result_r <= result_now;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    flag_sets_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ce_in && mismatch && !cc_touch_a) |=> flag_now)
        else $error("change flag not set on mismatch");
    flag_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ce_in && flag_now && !flag_wr) |=> flag_now)
        else $error("change flag cleared without a write");
    flag_swset_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ce_in && flag_wr && wbyte[3]) |=> flag_now)
        else $error("software set of flag lost");
    irq_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        core_irq_out |-> (flag_now && peripheral_enable_one_r[3] &&
                          core_interrupt_control_r[7:6] == 2'b11))
        else $error("interrupt raised without all enables");
    latch_access_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ce_in && cc_touch_a) |=> (latched_result_r == $past(result_now)))
        else $error("access did not latch result");
    persist_set_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ce_in && mismatch && !cc_touch_a)[*2] |=> flag_now)
        else $error("persisting mismatch did not keep flag");
    ladder_level_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        internal_ref_level_out[4] == !reference_ladder_control_r[5])
        else $error("ladder range level mismatch");
    reset_state_a: assert property (@(posedge clk_in)
        !rst_n_in |=> (comparator_control_r == 8'h00 && !ladder_power_on_out))
        else $error("reset state not loaded");
    off_mode_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (mode_code == 3'b111) |-> !comparator_on_out)
        else $error("comparator on in off mode");
    invert_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        cmp_on |-> (result_now == (raw_sync ^ comparator_control_r[4])))
        else $error("result inversion wrong");
endmodule : cmp_vref_ctrl

// ===== common/cmp_vref_defs.svh
// Constants for the comparator and reference-ladder control block.
// Assumes inclusion by bare name from design and testbench files.
`ifndef CMP_VREF_DEFS_SVH
`define CMP_VREF_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets (printed offsets are not all multiples of four: indices)
// ----------------------------------------------------------------------------
`define IDX_CORE_INT_CTRL   8'h0b
`define IDX_PERIPH_FLAG     8'h0c
`define IDX_CMP_CTRL        8'h19
`define IDX_PORTA_DIR       8'h85
`define IDX_PERIPH_EN       8'h8c
`define IDX_LADDER_CTRL     8'h99
`define IDX_LINK_STATUS     8'hf0

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_GLOBAL_EN       7
`define BIT_PERIPH_EN       6
`define BIT_CHANGE_FLAG     3
`define BIT_CHANGE_EN       3
`define BIT_RESULT          6
`define BIT_INVERT          4
`define BIT_SWITCH          3
`define BIT_LADDER_ON       7
`define BIT_RANGE_LOW       5

// ----------------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------------
`define RST_CORE_INT_CTRL   8'h00
`define RST_PERIPH_FLAG     8'h00
`define RST_CMP_CTRL        8'h00
`define RST_PORTA_DIR       8'h3f
`define RST_PERIPH_EN       8'h00
`define RST_LADDER_CTRL     8'h00
`define MASK_PERIPH         8'hc9
`define MASK_PORTA_DIR      8'h3f
`define MASK_CMP_CTRL       8'h1f
`define MASK_LADDER         8'haf

// ----------------------------------------------------------------------------
// Ladder arithmetic and synchroniser depth
// ----------------------------------------------------------------------------
`define LADDER_LOW_DIV      24
`define LADDER_HIGH_DIV     32
`define LADDER_HIGH_BASE    4
`define LADDER_LEVELS       32
`define SYNC_STAGES         3

`endif

// ===== common/cmp_vref_pkg.sv
// Types shared by the comparator and reference-ladder control block.
// Assumes the constants header is on the include path.
package cmp_vref_pkg;

    typedef enum logic [2:0] {
        MODE_RESET   = 3'b000,
        MODE_SW_LOW  = 3'b101,
        MODE_SW_HIGH = 3'b110,
        MODE_OFF     = 3'b111
    } cmp_mode_e;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DATA = 2'b10
    } bus_state_e;

endpackage : cmp_vref_pkg

// ===== hdl/pin_sync.sv
// Three-stage synchroniser for a level from outside the clock domain.
// Assumes a single clock; the output changes once stages two and three agree.
`timescale 1ns/1ps
module pin_sync #(
    parameter int STAGES = 3
) (
    // Clock and control
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic ce_in,
    // Level
    input  wire logic async_in,
    output logic      level_out
);
    logic [STAGES-1:0] chain_r;
    logic              level_nxt;

    // The first stage is read only by the second.
    assign level_nxt = (chain_r[STAGES-1] == chain_r[STAGES-2]) ?
                       chain_r[STAGES-1] : level_out;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            chain_r   <= '0;
            level_out <= 1'b0;
        end else if (ce_in) begin
            chain_r   <= {chain_r[STAGES-2:0], async_in};
            level_out <= level_nxt;
        end
    end
endmodule : pin_sync

// ===== test/comparator_vref_control_tb.sv
// Self-checking bench for the comparator and reference-ladder control block.
// Assumes the design header is on the include path and a zero-wait AHB-Lite slave.
`timescale 1ns/1ps
`include "cmp_vref_defs.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_errors++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module comparator_vref_control_tb;
    import cmp_vref_pkg::*;

    // ------------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------------
    logic        clk_in, rst_n_in, ce_in, hsel_in, hwrite_in, hready_in;
    logic [31:0] haddr_in, hwdata_in, hrdata_out;
    logic [1:0]  htrans_in;
    logic [2:0]  hsize_in, comparator_mode_code_out;
    logic        hreadyout_out, hresp_out, compare_raw_in, sleep_in;
    logic        result_invert_out, input_switch_out, neg_from_pos_pin_out;
    logic        comparator_on_out, ladder_power_on_out, ladder_range_low_out;
    logic [3:0]  ladder_tap_code_out;
    logic [4:0]  internal_ref_level_out;
    logic [5:0]  port_a_direction_out;
    logic        pins_all_analog_out, core_irq_out, wake_out;
    int          n_errors, num_checks, cycles;
    logic [31:0] d;

    // The single slave's ready is the bus ready.
    assign hready_in = hreadyout_out;

    cmp_vref_ctrl dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
        .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
        .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
        .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
        .hresp_out(hresp_out), .compare_raw_in(compare_raw_in), .sleep_in(sleep_in),
        .comparator_mode_code_out(comparator_mode_code_out),
        .result_invert_out(result_invert_out), .input_switch_out(input_switch_out),
        .neg_from_pos_pin_out(neg_from_pos_pin_out), .comparator_on_out(comparator_on_out),
        .ladder_power_on_out(ladder_power_on_out), .ladder_range_low_out(ladder_range_low_out),
        .ladder_tap_code_out(ladder_tap_code_out),
        .internal_ref_level_out(internal_ref_level_out),
        .port_a_direction_out(port_a_direction_out),
        .pins_all_analog_out(pins_all_analog_out), .core_irq_out(core_irq_out),
        .wake_out(wake_out));

    initial clk_in = 1'b0;
    always #10 clk_in = ~clk_in;

    // ------------------------------------------------------------------------
    // Bus and timing helpers
    // ------------------------------------------------------------------------
    // Waits end just after the edge so that the edge's updates have landed.
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : cyc

    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        hsel_in   <= 1'b1;
        haddr_in  <= {22'h00_0000, idx, 2'b00};
        htrans_in <= 2'b10;
        hwrite_in <= wr;
        hsize_in  <= 3'b010;
        n = 0;
        do begin @(posedge clk_in); n++; end while (hready_in !== 1'b1 && n < 50);
        htrans_in <= 2'b00;
        hsel_in   <= 1'b0;
        hwdata_in <= wd;
        n = 0;
        do begin @(posedge clk_in); n++; end while (hready_in !== 1'b1 && n < 50);
        rd = hrdata_out;
        #1;
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        logic [31:0] unused;
        bus(1'b1, idx, {24'h00_0000, v}, unused);
    endtask : wr

    task automatic rd(input logic [7:0] idx, output logic [31:0] v);
        bus(1'b0, idx, 32'h0000_0000, v);
    endtask : rd

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset();
        `CHK("mode_out", 3'b000, comparator_mode_code_out)
        `CHK("ladder_on", 1'b0, ladder_power_on_out)
        `CHK("all_analog", 1'b1, pins_all_analog_out)
        `CHK("cmp_on", 1'b0, comparator_on_out)
        `CHK("dir_out", 6'h3f, port_a_direction_out)
        `CHK("hresp", 1'b0, hresp_out)
        `CHK("hready", 1'b1, hreadyout_out)
        rd(`IDX_CMP_CTRL, d);    `CHK("cmp_ctrl", 32'h0000_0000, d)
        rd(`IDX_LADDER_CTRL, d); `CHK("ladder", 32'h0000_0000, d)
        rd(`IDX_PERIPH_FLAG, d); `CHK("flags", 32'h0000_0000, d)
        rd(`IDX_PORTA_DIR, d);   `CHK("dir", 32'h0000_003f, d)
        rd(8'h20, d);            `CHK("unmapped", 32'h0000_0000, d)
        $display("test reset done");
    endtask : t_reset

    task automatic t_ladder();
        logic [7:0] v;
        for (int r = 0; r < 2; r++) begin
            for (int t = 0; t < 16; t++) begin
                v = {2'b10, r[0], 1'b0, t[3:0]};
                wr(`IDX_LADDER_CTRL, v | 8'h50);
                rd(`IDX_LADDER_CTRL, d);
                `CHK("ladder_rb", {24'h00_0000, v & 8'haf}, d)
                `CHK("range_low", r[0], ladder_range_low_out)
                `CHK("tap", t[3:0], ladder_tap_code_out)
                `CHK("ref_level", {~r[0], t[3:0]}, internal_ref_level_out)
                `CHK("ladder_on", 1'b1, ladder_power_on_out)
            end
        end
        wr(`IDX_LADDER_CTRL, 8'h00);
        `CHK("ladder_off", 1'b0, ladder_power_on_out)
        $display("test ladder done");
    endtask : t_ladder

    task automatic t_modes();
        logic [2:0] m;
        logic       sw, inv, on;
        compare_raw_in <= 1'b1;
        cyc(8);
        for (int i = 0; i < 16; i++) begin
            m = i[2:0];
            sw = i[3];
            inv = i[3] ^ i[0];
            on = (m != 3'b000) && (m != 3'b111);
            wr(`IDX_CMP_CTRL, {3'b111, inv, sw, m});
            rd(`IDX_CMP_CTRL, d);
            `CHK("cmp_rb", {24'h0, 1'b0, on & ~inv, 1'b0, inv, sw, m}, d)
            `CHK("mode_out", m, comparator_mode_code_out)
            `CHK("inv_out", inv, result_invert_out)
            `CHK("sw_out", sw, input_switch_out)
            `CHK("cmp_on", on, comparator_on_out)
            `CHK("neg_pos", (m == 3'b101 || m == 3'b110) && sw, neg_from_pos_pin_out)
            `CHK("all_analog", m == 3'b000, pins_all_analog_out)
        end
        $display("test modes done");
    endtask : t_modes

    task automatic t_flag();
        int n;
        wr(`IDX_PERIPH_EN, 8'h00);
        wr(`IDX_CORE_INT_CTRL, 8'h00);
        wr(`IDX_CMP_CTRL, 8'h05);
        // Enabling the comparator leaves a mismatch; an access latches it first.
        rd(`IDX_CMP_CTRL, d);
        wr(`IDX_PERIPH_FLAG, 8'h00);
        rd(`IDX_PERIPH_FLAG, d); `CHK("flag_clr", 32'h0000_0000, d)
        compare_raw_in <= 1'b0;
        cyc(8);
        rd(`IDX_PERIPH_FLAG, d); `CHK("flag_set", 32'h0000_0008, d)
        `CHK("irq_off", 1'b0, core_irq_out)
        wr(`IDX_PERIPH_FLAG, 8'h00);
        rd(`IDX_PERIPH_FLAG, d); `CHK("flag_persist", 32'h0000_0008, d)
        rd(`IDX_CMP_CTRL, d);
        wr(`IDX_PERIPH_FLAG, 8'h00);
        rd(`IDX_PERIPH_FLAG, d); `CHK("flag_latched", 32'h0000_0000, d)
        cyc(10);
        rd(`IDX_PERIPH_FLAG, d); `CHK("flag_holds", 32'h0000_0000, d)
        wr(`IDX_PERIPH_FLAG, 8'h08);
        rd(`IDX_PERIPH_FLAG, d); `CHK("flag_sw_set", 32'h0000_0008, d)
        for (int i = 0; i < 8; i++) begin
            wr(`IDX_CORE_INT_CTRL, {i[2], i[1], 6'h00});
            wr(`IDX_PERIPH_EN, {4'h0, i[0], 3'h0});
            `CHK("irq_gate", &i[2:0], core_irq_out)
        end
        wr(`IDX_PERIPH_FLAG, 8'h00);
        compare_raw_in <= 1'b1;
        cyc(2);
        `CHK("irq_sync", 1'b0, core_irq_out)
        n = 0;
        while (core_irq_out !== 1'b1 && n < 8) begin cyc(1); n++; end
        `CHK("irq_change", 1'b1, core_irq_out)
        $display("test flag done");
    endtask : t_flag

    task automatic t_sleep();
        rd(`IDX_CMP_CTRL, d);
        `CHK("result_bit", 1'b1, d[6])
        wr(`IDX_LADDER_CTRL, 8'ha5);
        wr(`IDX_PERIPH_FLAG, 8'h00);
        sleep_in <= 1'b1;
        cyc(2);
        `CHK("wake_idle", 1'b0, wake_out)
        `CHK("cmp_sleep", 1'b1, comparator_on_out)
        `CHK("ladder_sleep", 1'b1, ladder_power_on_out)
        compare_raw_in <= 1'b0;
        cyc(8);
        `CHK("wake", 1'b1, wake_out)
        sleep_in <= 1'b0;
        cyc(1);
        rd(`IDX_CMP_CTRL, d);    `CHK("cmp_kept", 32'h0000_0005, d)
        rd(`IDX_LADDER_CTRL, d); `CHK("ladder_kept", 32'h0000_00a5, d)
        wr(`IDX_CMP_CTRL, 8'h07);
        sleep_in <= 1'b1;
        cyc(1);
        `CHK("cmp_off", 1'b0, comparator_on_out)
        `CHK("wake_off", 1'b0, wake_out)
        sleep_in <= 1'b0;
        // With the clock enable low the write must not land.
        ce_in <= 1'b0;
        wr(`IDX_LADDER_CTRL, 8'h00);
        ce_in <= 1'b1;
        cyc(1);
        `CHK("ce_freeze", 1'b1, ladder_power_on_out)
        $display("test sleep done");
    endtask : t_sleep

    // ------------------------------------------------------------------------
    // Closing and sequence
    // ------------------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude

    // The run needs a few hundred cycles; the ceiling leaves ample margin.
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            $display("MISMATCH timeout expected 0 seen %0d", cycles);
            conclude();
        end
    end

    initial begin
        {rst_n_in, hsel_in, hwrite_in, compare_raw_in, sleep_in} = 5'b00000;
        ce_in = 1'b1;
        haddr_in = 32'h0000_0000;
        hwdata_in = 32'h0000_0000;
        htrans_in = 2'b00;
        hsize_in = 3'b010;
        n_errors = 0;
        num_checks = 0;
        cycles = 0;
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        cyc(1);
        t_reset();
        t_ladder();
        t_modes();
        t_flag();
        t_sleep();
        conclude();
    end
endmodule : comparator_vref_control_tb
